// *** hdl/rsp_defines.svh ***
/*
 * Register offsets, field positions, reset values for the return stack
 * and program counter block.
 * Assumes: included by the design module by bare name.
 */
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define RSP_OFF_RETURN_STACK_POINTER   12'h000
`define RSP_OFF_TOPL     12'h004
`define RSP_OFF_TOPH     12'h008
`define RSP_OFF_TOPU     12'h00C
`define RSP_OFF_PCL      12'h010
`define RSP_OFF_PC_HIGH_LATCH   12'h014
`define RSP_OFF_PC_UPPER_LATCH   12'h018
`define RSP_OFF_CTRL     12'h01C
`define RSP_OFF_PCFULL   12'h020

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define RSP_FULL_BIT     7
`define RSP_UNF_BIT      6
`define RSP_SP_MSB       4
`define RSP_SP_MAX       5'h1F
`define RSP_PC_STEP      21'h000002
`define RSP_CTRL_RESET   1'b1

`endif

// *** hdl/rsp_pkg.sv ***
/*
 * Types for the return stack and program counter block.
 * Assumes: rsp_defines.svh sits on the include path.
 */
package rsp_pkg;

  typedef logic [20:0] rsp_pc_t;

  typedef enum logic [3:0] {
    RSP_OP_NONE,
    RSP_OP_SEQ,
    RSP_OP_JUMP,
    RSP_OP_CALL,
    RSP_OP_RETURN,
    RSP_OP_INTR,
    RSP_OP_PUSH,
    RSP_OP_POP
  } rsp_op_t;

  // core-facing request
  typedef struct packed {
    rsp_op_t     op;
    logic        fast;
    rsp_pc_t     target;
    logic [7:0]  status;
    logic [7:0]  working_register;
    logic [7:0]  bank_select_register;
  } rsp_core_req_t;

  // shadow restore to core
  typedef struct packed {
    logic        restore;
    logic [7:0]  status;
    logic [7:0]  working_register;
    logic [7:0]  bank_select_register;
  } rsp_shadow_t;

  typedef struct packed {
    logic [4:0]  sp;
    logic        full;
    logic        unf;
    logic        fault_rst_en;
    rsp_pc_t     pc;
    logic [7:0]  lat_h;
    logic [4:0]  lat_u;
    rsp_shadow_t shadow;
    rsp_shadow_t restore_out;
    logic        fault_reset;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } rsp_state_t;

endpackage : rsp_pkg

// *** hdl/rsp_stack.sv ***
/*
 * Return address stack, stack pointer with sticky full and underflow
 * flags, one-level shadow registers and the 21-bit program counter with its
 * latch registers, reached over APB.
 * Assumes: the core issues one op per cycle and takes a device reset
 * when fault_reset pulses; por_n is power-on reset, presetn device reset.
 */
// Operation
// - pointer ranges 0..31, push up, pop down
// - reset loads pointer with zero
// - software reads and writes pointer
// - full flag set on 31st push
// - full flag cleared only by software/POR
// - fault reset on: push PC+2, reset
// - fault reset off: pointer stays 31
// - empty pop sets underflow, empty return loads zero
// - underflow cleared only by software/POR
// - flag first, then reset if enabled
// - full bit7, underflow bit6, pointer 4:0
// - push instruction increments, stores PC+2
// - pop instruction discards top entry
// - interrupt loads hidden shadow registers
// - fast return restores shadow registers
// - any priority interrupt overwrites shadow
// - fast call loads shadow registers
// - PC 21 bits, upper parts via latches
// - PC bit0 zero, advance by two
// - calls, jumps load PC directly
// - low byte write loads latches into PC
// - low byte read copies PC into latches
// - 31x21 stack, zero has no storage
// - top entry bytes readable and writable
`timescale 1ns/100ps
`default_nettype none
`include "rsp_defines.svh"

module rsp_stack
  import rsp_pkg::*;
#(
  parameter int DEPTH = 31
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          por_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  input  wire rsp_core_req_t core_req,
  output var  rsp_pc_t       pc,
  output var  rsp_shadow_t   shadow_restore,
  output var  logic          fault_reset
);

  // elaboration check: the pointer and storage serve 31 entries only
  if (DEPTH != 31)
  begin : g_depth_check
    $error("rsp_stack: DEPTH must be 31");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rsp_state_t  st;
  rsp_state_t  next_st;
  logic [20:0] mem [1:DEPTH];
  logic        mem_we;
  logic [4:0]  mem_wa;
  rsp_pc_t     mem_wd;
  logic        sticky_full;
  logic        sticky_unf;
  logic        next_sticky_full;
  logic        next_sticky_unf;

  wire logic   acc   = psel & penable & ~st.pready;
  wire logic   wr    = acc & pwrite & pstrb[0];
  wire logic   rd    = acc & ~pwrite;
  wire rsp_pc_t top_of_stack  = (st.sp == 5'h00) ? 21'h0 : mem[st.sp];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_sticky_full = sticky_full;
    next_sticky_unf  = sticky_unf;
    next_st.fault_reset = 1'b0;
    next_st.restore_out.restore = 1'b0;
    next_st.pready  = acc;
    next_st.pslverr = 1'b0;
    mem_we = 1'b0;
    mem_wa = st.sp;
    mem_wd = st.pc;
    // software clears first, hardware sets below win
    if (wr && paddr == `RSP_OFF_RETURN_STACK_POINTER)
    begin
      next_st.sp = pwdata[`RSP_SP_MSB:0];
      if (!pwdata[`RSP_FULL_BIT])
        next_sticky_full = 1'b0;
      if (!pwdata[`RSP_UNF_BIT])
        next_sticky_unf = 1'b0;
    end
    unique case (core_req.op)
      RSP_OP_SEQ:
        next_st.pc = st.pc + `RSP_PC_STEP;
      RSP_OP_JUMP:
        next_st.pc = {core_req.target[20:1], 1'b0};
      RSP_OP_CALL, RSP_OP_INTR, RSP_OP_PUSH:
      begin
        if (core_req.op != RSP_OP_PUSH)
          next_st.pc = {core_req.target[20:1], 1'b0};
        else
          next_st.pc = st.pc + `RSP_PC_STEP;
        if (core_req.op == RSP_OP_INTR ||
            (core_req.op == RSP_OP_CALL && core_req.fast))
        begin
          next_st.shadow.status = core_req.status;
          next_st.shadow.working_register   = core_req.working_register;
          next_st.shadow.bank_select_register    = core_req.bank_select_register;
        end
        if (st.sp != `RSP_SP_MAX)
        begin
          mem_we = 1'b1;
          mem_wa = st.sp + 5'h01;
          mem_wd = st.pc + `RSP_PC_STEP;
          next_st.sp = st.sp + 5'h01;
          if (st.sp + 5'h01 == `RSP_SP_MAX)
          begin
            next_sticky_full = 1'b1;
            if (st.fault_rst_en)
            begin
              next_st.fault_reset = 1'b1;
              next_st.sp = 5'h00;
              next_st.pc = 21'h0;
            end
          end
        end
        else
          next_sticky_full = 1'b1;
      end
      RSP_OP_RETURN, RSP_OP_POP:
      begin
        if (core_req.op == RSP_OP_RETURN)
        begin
          next_st.pc = {top_of_stack[20:1], 1'b0};
          if (core_req.fast)
          begin
            next_st.restore_out = st.shadow;
            next_st.restore_out.restore = 1'b1;
          end
        end
        else
          next_st.pc = st.pc + `RSP_PC_STEP;
        if (st.sp == 5'h00)
        begin
          next_sticky_unf = 1'b1;
          if (core_req.op == RSP_OP_RETURN)
            next_st.pc = 21'h0;
          if (st.fault_rst_en)
          begin
            next_st.fault_reset = 1'b1;
            next_st.pc = 21'h0;
          end
        end
        else
          next_st.sp = st.sp - 5'h01;
      end
      default:
        ;
    endcase
    // register writes of the stack top, program counter, latches and control
    if (wr)
    begin
      unique case (paddr)
        `RSP_OFF_TOPL, `RSP_OFF_TOPH, `RSP_OFF_TOPU:
          if (st.sp != 5'h00)
          begin
            mem_we = 1'b1;
            mem_wa = st.sp;
            mem_wd = top_of_stack;
            if (paddr == `RSP_OFF_TOPL)
              mem_wd[7:0] = pwdata[7:0];
            else if (paddr == `RSP_OFF_TOPH)
              mem_wd[15:8] = pwdata[7:0];
            else
              mem_wd[20:16] = pwdata[4:0];
          end
        `RSP_OFF_PCL:
          next_st.pc = {st.lat_u, st.lat_h, pwdata[7:1], 1'b0};
        `RSP_OFF_PC_HIGH_LATCH:
          next_st.lat_h = pwdata[7:0];
        `RSP_OFF_PC_UPPER_LATCH:
          next_st.lat_u = pwdata[4:0];
        `RSP_OFF_CTRL:
          next_st.fault_rst_en = pwdata[0];
        `RSP_OFF_RETURN_STACK_POINTER, `RSP_OFF_PCFULL:
          ;
        default:
          next_st.pslverr = 1'b1;
      endcase
    end
    else if (acc && pwrite)
      next_st.pslverr = !(paddr <= `RSP_OFF_PCFULL && paddr[1:0] == 2'b00);
    if (rd)
    begin
      next_st.prdata = 32'h0;
      unique case (paddr)
        `RSP_OFF_RETURN_STACK_POINTER:
          next_st.prdata[7:0] = {sticky_full, sticky_unf, 1'b0, st.sp};
        `RSP_OFF_TOPL:   next_st.prdata[7:0] = top_of_stack[7:0];
        `RSP_OFF_TOPH:   next_st.prdata[7:0] = top_of_stack[15:8];
        `RSP_OFF_TOPU:   next_st.prdata[4:0] = top_of_stack[20:16];
        `RSP_OFF_PCL:
        begin
          next_st.prdata[7:0] = st.pc[7:0];
          next_st.lat_h = st.pc[15:8];
          next_st.lat_u = st.pc[20:16];
        end
        `RSP_OFF_PC_HIGH_LATCH: next_st.prdata[7:0] = st.lat_h;
        `RSP_OFF_PC_UPPER_LATCH: next_st.prdata[4:0] = st.lat_u;
        `RSP_OFF_CTRL:   next_st.prdata[0] = st.fault_rst_en;
        `RSP_OFF_PCFULL: next_st.prdata[20:0] = st.pc;
        default:         next_st.pslverr = 1'b1;
      endcase
    end
    next_st.full = next_sticky_full;
    next_st.unf  = next_sticky_unf;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.fault_rst_en <= `RSP_CTRL_RESET;
    end
    else if (st.fault_reset)
    begin
      st <= '0;
      st.fault_rst_en <= st.fault_rst_en;
    end
    else
      st <= next_st;
  end

  // flags survive device reset, only power-on or a software write clears them
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      sticky_full <= 1'b0;
      sticky_unf  <= 1'b0;
    end
    else
    begin
      sticky_full <= next_sticky_full;
      sticky_unf  <= next_sticky_unf;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (mem_we && presetn && mem_wa != 5'h00)
      mem[mem_wa] <= mem_wd;
  end

  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign pc             = st.pc;
  assign shadow_restore = st.restore_out;
  assign fault_reset    = st.fault_reset;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  pc_even_a: assert property (@(posedge pclk) disable iff (!presetn)
    pc[0] == 1'b0) else $error("pc bit 0 set");
  pc_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_SEQ && !st.fault_reset && !wr
    |=> pc == $past(pc) + 21'h2) else $error("pc step wrong");
  push_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_PUSH && st.sp < 5'h1E && !wr && !st.fault_reset
    |=> st.sp == $past(st.sp) + 5'h1) else $error("push sp");
  full_set_a: assert property (@(posedge pclk) disable iff (!por_n || !presetn)
    core_req.op == RSP_OP_CALL && st.sp == 5'h1E && !st.fault_reset
    |=> sticky_full) else $error("full not set");
  fault_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_CALL && st.sp == 5'h1E && st.fault_rst_en
    && !st.fault_reset && !wr |=> fault_reset ##1 st.sp == 5'h0)
    else $error("fault reset missing");
  hold_31_a: assert property (@(posedge pclk) disable iff (!presetn)
    st.sp == 5'h1F && !wr && core_req.op == RSP_OP_CALL && !st.fault_reset
    |=> st.sp == 5'h1F) else $error("sp passed 31");
  unf_set_a: assert property (@(posedge pclk) disable iff (!por_n || !presetn)
    core_req.op == RSP_OP_RETURN && st.sp == 5'h0 && !st.fault_reset
    |=> sticky_unf && pc == 21'h0) else $error("underflow");
  pcl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `RSP_OFF_PCL && !st.fault_reset
    |=> pc[20:8] == {$past(st.lat_u), $past(st.lat_h)})
    else $error("pcl write");
  fast_ret_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_RETURN && core_req.fast && !st.fault_reset
    |=> shadow_restore.restore &&
        shadow_restore.working_register == $past(st.shadow.working_register))
    else $error("fast return");

  // ----------------------------------------------------------------------
  // checks on pointer, flags, shadow, program counter loads and the pready pulse
  // ----------------------------------------------------------------------
  pop_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_POP && st.sp != 5'h0 && !wr && !st.fault_reset
    |=> st.sp == $past(st.sp) - 5'h1)
    else $error("pop sp");
  sp_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == `RSP_OFF_RETURN_STACK_POINTER && core_req.op == RSP_OP_NONE
    && !st.fault_reset |=> st.sp == $past(pwdata[4:0]))
    else $error("sp write");
  sp_bit5_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == `RSP_OFF_RETURN_STACK_POINTER && !st.fault_reset
    |=> prdata[5] == 1'b0)
    else $error("sp bit 5 set");
  full_sticky_a: assert property (@(posedge pclk) disable iff (!por_n)
    sticky_full && !(wr && paddr == `RSP_OFF_RETURN_STACK_POINTER && !pwdata[7])
    |=> sticky_full)
    else $error("full flag lost");
  unf_sticky_a: assert property (@(posedge pclk) disable iff (!por_n)
    sticky_unf && !(wr && paddr == `RSP_OFF_RETURN_STACK_POINTER && !pwdata[6])
    |=> sticky_unf)
    else $error("underflow flag lost");
  pcl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == `RSP_OFF_PCL && !st.fault_reset
    |=> {st.lat_u, st.lat_h} == $past(pc[20:8]))
    else $error("pcl read");
  jump_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_JUMP && !wr && !st.fault_reset
    |=> pc == {$past(core_req.target[20:1]), 1'b0})
    else $error("jump load");
  intr_shadow_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_INTR && !st.fault_reset
    |=> st.shadow.status == $past(core_req.status))
    else $error("interrupt shadow");
  fast_call_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_CALL && core_req.fast && !st.fault_reset
    |=> st.shadow.bank_select_register == $past(core_req.bank_select_register))
    else $error("fast call shadow");
  ret_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_RETURN && st.sp != 5'h0 && !wr && !st.fault_reset
    |=> pc == {$past(top_of_stack[20:1]), 1'b0})
    else $error("return load");
  ret_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_req.op == RSP_OP_RETURN && core_req.fast && !st.fault_reset
    |=> shadow_restore.status == $past(st.shadow.status))
    else $error("fast return status");
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held");

  // ----------------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------------
  push_c: cover property (@(posedge pclk) core_req.op == RSP_OP_CALL);
  fault_c: cover property (@(posedge pclk) fault_reset);
  full_c: cover property (@(posedge pclk) $rose(sticky_full));
  unf_c:  cover property (@(posedge pclk) $rose(sticky_unf));
  pcl_c:  cover property (@(posedge pclk) wr && paddr == `RSP_OFF_PCL);

endmodule : rsp_stack
`default_nettype wire

// *** verification/rsp_core_model.sv ***
/*
 * Core-side model: the instruction decoder and interrupt sequencer that
 * hand one op request at a time to the return stack block.
 * Assumes: the testbench calls issue() and never overlaps two calls.
 */
`timescale 1ns/100ps
`default_nettype none

module rsp_core_model
  import rsp_pkg::*;
(
  input  wire logic          pclk,
  output var  rsp_core_req_t core_req
);
  // ------------------------------------------------------------------
  // op request driver
  // ------------------------------------------------------------------
  initial core_req = '0;

  // one op for one cycle, then idle while the block settles
  task automatic issue(input rsp_op_t op, input logic fast,
                       input rsp_pc_t tgt, input logic [23:0] regs);
    @(posedge pclk);
    core_req <= '{op, fast, tgt, regs[23:16], regs[15:8], regs[7:0]};
    @(posedge pclk);
    core_req.op <= RSP_OP_NONE;
    repeat (3) @(posedge pclk);
  endtask : issue
endmodule : rsp_core_model
`default_nettype wire

// *** verification/testbench.sv ***
/*
 * Self-checking bench for the return stack block: APB master tasks,
 * one task per scenario, pulse monitors and the closing verdict.
 * Assumes: rsp_pkg compiled first, core model in rsp_core_model.sv.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import rsp_pkg::*;
  // ------------------------------------------------------------------
  // signals, instances, monitors
  // ------------------------------------------------------------------
  localparam logic [11:0] a_sp = 12'h000, a_tl = 12'h004, a_th = 12'h008;
  localparam logic [11:0] a_tu = 12'h00C, a_pl = 12'h010, a_lh = 12'h014;
  localparam logic [11:0] a_lu = 12'h018, a_ct = 12'h01C;
  logic          pclk, presetn, por_n, psel, penable, pwrite, pready;
  logic          pslverr, fault_reset, err;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  rsp_core_req_t core_req;
  rsp_pc_t       pc;
  rsp_shadow_t   shadow_restore, rest;
  int            miscompares, tests_run, faults, restores, f;

  rsp_stack i_rsp_stack (.pclk(pclk), .presetn(presetn), .por_n(por_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(core_req), .pc(pc),
    .shadow_restore(shadow_restore), .fault_reset(fault_reset));
  rsp_core_model i_rsp_core_model (.pclk(pclk), .core_req(core_req));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    if (fault_reset === 1'b1) faults++;
    if (shadow_restore.restore === 1'b1)
    begin
      restores++;
      rest = shadow_restore;
    end
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input string n, input logic [11:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask : rc

  task automatic op(input rsp_op_t o, input logic fs, input rsp_pc_t t,
                    input logic [23:0] r);
    i_rsp_core_model.issue(o, fs, t, r);
  endtask : op

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset;
    rc("sp", a_sp, 32'h0);
    rc("ctrl", a_ct, 32'h1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h0FC, 32'h0);
    chk("unmapped wr", {31'h0, err}, 32'h1);
    chk("pc", {11'h0, pc}, 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_pc;
    op(RSP_OP_JUMP, 1'b0, 21'h1ABCD4, 24'h0);
    chk("pc", {11'h0, pc}, 32'h1ABCD4);
    op(RSP_OP_SEQ, 1'b0, 21'h0, 24'h0);
    chk("pc", {11'h0, pc}, 32'h1ABCD6);
    rc("pcl", a_pl, 32'hD6);
    rc("lath", a_lh, 32'hBC);
    rc("latu", a_lu, 32'h1A);
    apb(1'b1, a_lh, 32'h12);
    apb(1'b1, a_lu, 32'h05);
    chk("pc", {11'h0, pc}, 32'h1ABCD6);
    apb(1'b1, a_pl, 32'h35);
    chk("pc", {11'h0, pc}, 32'h051234);
    rc("pcfull", 12'h020, 32'h051234);
    $display("test pc done");
  endtask : test_pc

  task automatic test_stack;
    op(RSP_OP_CALL, 1'b0, 21'h000100, 24'h0);
    chk("pc", {11'h0, pc}, 32'h100);
    rc("sp", a_sp, 32'h1);
    rc("tl", a_tl, 32'h36);
    rc("th", a_th, 32'h12);
    rc("tu", a_tu, 32'h05);
    op(RSP_OP_PUSH, 1'b0, 21'h0, 24'h0);
    rc("sp", a_sp, 32'h2);
    rc("tl", a_tl, 32'h02);
    rc("th", a_th, 32'h01);
    apb(1'b1, a_tl, 32'h40);
    rc("tl", a_tl, 32'h40);
    op(RSP_OP_POP, 1'b0, 21'h0, 24'h0);
    rc("sp", a_sp, 32'h1);
    op(RSP_OP_RETURN, 1'b0, 21'h0, 24'h0);
    chk("pc", {11'h0, pc}, 32'h051236);
    rc("sp", a_sp, 32'h0);
    $display("test stack done");
  endtask : test_stack

  task automatic test_faults;
    f = faults;
    op(RSP_OP_JUMP, 1'b0, 21'h000444, 24'h0);
    op(RSP_OP_RETURN, 1'b0, 21'h0, 24'h0);
    chk("faults", faults, f + 1);
    chk("pc", {11'h0, pc}, 32'h0);
    rc("sp", a_sp, 32'h40);
    apb(1'b1, a_sp, 32'h0);
    rc("sp", a_sp, 32'h0);
    apb(1'b1, a_ct, 32'h0);
    apb(1'b1, a_sp, 32'h1E);
    rc("sp", a_sp, 32'h1E);
    op(RSP_OP_JUMP, 1'b0, 21'h000200, 24'h0);
    op(RSP_OP_CALL, 1'b0, 21'h000300, 24'h0);
    rc("sp", a_sp, 32'h9F);
    op(RSP_OP_CALL, 1'b0, 21'h000400, 24'h0);
    rc("sp", a_sp, 32'h9F);
    rc("th", a_th, 32'h02);
    chk("faults", faults, f + 1);
    apb(1'b1, a_ct, 32'h1);
    apb(1'b1, a_sp, 32'h1E);
    op(RSP_OP_CALL, 1'b0, 21'h000500, 24'h0);
    chk("faults", faults, f + 2);
    chk("pc", {11'h0, pc}, 32'h0);
    rc("sp", a_sp, 32'h80);
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc("sp", a_sp, 32'h80);
    @(posedge pclk) por_n <= 1'b0;
    repeat (2) @(posedge pclk);
    por_n <= 1'b1;
    rc("sp", a_sp, 32'h0);
    $display("test faults done");
  endtask : test_faults

  task automatic test_shadow;
    op(RSP_OP_INTR, 1'b0, 21'h000008, 24'h112233);
    op(RSP_OP_INTR, 1'b0, 21'h000018, 24'h445566);
    f = restores;
    op(RSP_OP_RETURN, 1'b1, 21'h0, 24'h0);
    chk("restores", restores, f + 1);
    chk("shadow", {8'h0, rest[23:0]}, 32'h445566);
    op(RSP_OP_CALL, 1'b1, 21'h000600, 24'h778899);
    op(RSP_OP_RETURN, 1'b1, 21'h0, 24'h0);
    chk("shadow", {8'h0, rest[23:0]}, 32'h778899);
    op(RSP_OP_RETURN, 1'b0, 21'h0, 24'h0);
    chk("restores", restores, f + 2);
    $display("test shadow done");
  endtask : test_shadow

  // ------------------------------------------------------------------
  // sequence and verdict
  // ------------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    presetn = 1'b0; por_n = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    miscompares = 0; tests_run = 0; faults = 0; restores = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    test_reset;
    test_pc;
    test_stack;
    test_faults;
    test_shadow;
    print_verdict;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
